// ===== verilog/urb_receiver.sv
// Asynchronous serial receiver with two-entry buffer and Wishbone register slave
`include "urb_consts.svh"

// Summary of operation
// - Complete flag is one while buffer holds an unread character, else zero.
// - Clearing receiver enable empties the buffer so complete flag reads zero.
// - Complete interrupt asserted while flag, its enable and global enable set.
// - Data register read pops oldest character; software reads it to clear.
// - Error status stored with each character; read status before data.
// - Software writes to the three error flag positions are ignored.
// - Error flags never raise an interrupt request.
// - Frame error shows first stop bit of next readable frame, one if low.
// - Only first stop bit checked for framing; extra stop bits ignored.
// - Overrun when buffer full, shifter holds character, new start bit seen.
// - Overrun indication clears when a frame moves into the buffer.
// - Parity checked only when enabled; type bit selects odd or even.
// - Parity error set only if checking enabled at arrival and mismatched.
// - A character received with parity checking disabled has its parity error flag zero.
// - Disabling receiver acts at once, drops frame and buffered data.
// - Line sampled at 16x baud normally, 8x in double speed.
// - Start bit checked at samples 8-10 or 4-6; rejected if two high.
// - Each bit decided by majority of three centre samples.
// - After first stop bit the frame moves from shifter to buffer.
// - Ninth bit presented from buffer in control bit; read before data.
module urb_receiver
#(
  parameter int BAUD_W = 12
)
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Serial line and port handover
  input  wire logic        i_rxd,
  output logic             o_rx_pin_owned,
  // Interrupt request
  output logic             o_rx_irq,
  // Extra baud divider register selected by address bit 4 is not used; divider below
  output logic             o_overrun_event
);
  import urb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]        ctrl_b_reg;
  logic [7:0]        ctrl_c_reg;
  logic              u2x_reg;
  logic [BAUD_W-1:0] baud_reg;
  logic              receiver_enable_bit;
  logic              rd_data;
  logic              wb_req;

  assign receiver_enable_bit   = ctrl_b_reg[`URB_B_RECEIVER_ENABLE_BIT];
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign rd_data = wb_req && !i_wb_we && (i_wb_adr == `URB_OFF_DATA);

  // Baud divider lives in the upper half of control_c's word
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ctrl_b_reg <= `URB_RST_B;
      ctrl_c_reg <= `URB_RST_C;
      u2x_reg    <= 1'b0;
      baud_reg   <= `URB_RST_BAUD;
    end
    else if (wb_req && i_wb_we)
    begin
      unique case (i_wb_adr)
        `URB_OFF_STATUS_A:  if (i_wb_sel[0]) u2x_reg <= i_wb_dat[`URB_A_U2X];
        `URB_OFF_CONTROL_B: if (i_wb_sel[0]) ctrl_b_reg <= i_wb_dat[7:0];
        `URB_OFF_CONTROL_C:
        begin
          if (i_wb_sel[0]) ctrl_c_reg <= i_wb_dat[7:0];
          if (i_wb_sel[2]) baud_reg <= i_wb_dat[16 +: BAUD_W];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line synchroniser and sample tick
  logic rxd_s;
  urb_sync u_sync
  (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   (i_rxd),
    .o_sync    (rxd_s)
  );

  logic [BAUD_W-1:0] div_reg;
  logic              tick;
  assign tick = (div_reg == '0);
  // Tick runs at 16x (or 8x) baud; software picks the divider
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || !receiver_enable_bit)
      div_reg <= '0;
    else if (tick)
      div_reg <= baud_reg;
    else
      div_reg <= div_reg - 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Recovery state machine
  urb_state_t  state_reg;
  logic [4:0]  samp_reg;
  logic [3:0]  bit_reg;
  logic [2:0]  vote_reg;
  logic [8:0]  shift_reg;
  logic        par_bit_reg;
  logic        rxd_d_reg;
  logic        frame_done;
  logic        stop_bit;
  logic [4:0]  ovs;
  logic [4:0]  vote_at;
  logic [3:0]  nbits;
  logic        maj;
  logic        pen;

  assign ovs     = u2x_reg ? `URB_OVS_DOUBLE : `URB_OVS_NORMAL;
  assign vote_at = u2x_reg ? `URB_VOTE_DOUBLE : `URB_VOTE_NORMAL;
  assign pen     = ctrl_c_reg[`URB_C_PEN];

  function automatic logic [3:0] char_bits(input logic [2:0] csz);
    unique case (csz)
      3'h0: char_bits = 4'h5;
      3'h1: char_bits = 4'h6;
      3'h2: char_bits = 4'h7;
      3'h7: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction : char_bits

  assign nbits = char_bits({ctrl_b_reg[`URB_B_UCSZ2],
                            ctrl_c_reg[`URB_C_CSZ_HI:`URB_C_CSZ_LO]});
  // Two or more of three samples win
  assign maj = (vote_reg[0] & vote_reg[1]) | (vote_reg[1] & vote_reg[2])
             | (vote_reg[0] & vote_reg[2]);

  logic samp_end;  // Last of the three centre samples taken
  assign samp_end = tick && (samp_reg == vote_at + 5'h2);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || !receiver_enable_bit)
    begin
      state_reg <= URB_IDLE;
      samp_reg  <= '0;
      bit_reg   <= '0;
      vote_reg  <= '0;
      shift_reg <= '0;
      par_bit_reg <= 1'b0;
      rxd_d_reg <= 1'b1;
    end
    else if (tick)
    begin
      rxd_d_reg <= rxd_s;
      if (samp_reg >= vote_at && samp_reg <= vote_at + 5'h2)
        vote_reg <= {rxd_s, vote_reg[2:1]};
      unique case (state_reg)
        URB_IDLE:
          if (rxd_d_reg && !rxd_s)
          begin
            state_reg <= URB_START;
            samp_reg  <= 5'h2;  // The first low sample counts as sample 1
          end
        URB_START:
          if (samp_end)
          begin
            state_reg <= ((rxd_s & vote_reg[2]) | (vote_reg[2] & vote_reg[1])
                          | (rxd_s & vote_reg[1])) ? URB_IDLE : URB_START;
            samp_reg  <= samp_reg + 1'b1;
            bit_reg   <= '0;
          end
          else if (samp_reg == ovs)
          begin
            state_reg <= URB_DATA;
            samp_reg  <= 5'h1;
          end
          else
            samp_reg <= samp_reg + 1'b1;
        URB_DATA, URB_PAR, URB_STOP:
        begin
          samp_reg <= (samp_reg == ovs) ? 5'h1 : samp_reg + 1'b1;
          if (samp_reg == ovs)
          begin
            if (state_reg == URB_DATA)
            begin
              shift_reg <= {maj, shift_reg[8:1]};
              bit_reg   <= bit_reg + 1'b1;
              if (bit_reg == nbits - 4'h1)
                state_reg <= pen ? URB_PAR : URB_STOP;
            end
            else if (state_reg == URB_PAR)
            begin
              par_bit_reg <= maj;
              state_reg   <= URB_STOP;
            end
          end
          if (state_reg == URB_STOP && tick && samp_reg == vote_at + 5'h3)
            state_reg <= URB_IDLE;
        end
        default: state_reg <= URB_IDLE;
      endcase
    end
  end

  // Stop bit decided one sample after its vote; new start may follow at once
  assign frame_done = tick && state_reg == URB_STOP && samp_reg == vote_at + 5'h3;
  assign stop_bit   = maj;

  // Assemble the frame with masked upper bits and its status
  logic [8:0] frame_data;
  logic       frame_pe;
  always_comb
  begin
    frame_data = shift_reg >> (4'h9 - nbits);
    frame_pe   = 1'b0;
    if (pen)
      frame_pe = (^frame_data) ^ par_bit_reg ^ ctrl_c_reg[`URB_C_PODD];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer plus waiting shifter slot
  logic [11:0] buf_reg [`URB_BUF_DEPTH];  // {pe, dor, fe, data[8:0]}
  logic [1:0]  cnt_reg;
  logic        rp_reg;
  logic        wp_reg;
  logic        hold_reg;   // Character parked in shift register, buffer full
  logic [11:0] hold_data_reg;
  logic        dor_pend_reg;
  logic        push;
  logic [11:0] push_word;
  logic        pop;

  assign pop  = rd_data && cnt_reg != 2'h0;
  assign push = (frame_done && !hold_reg && (cnt_reg != 2'h2 || pop))
              || (hold_reg && pop);
  assign push_word = hold_reg ? hold_data_reg
                   : {frame_pe, dor_pend_reg, !stop_bit, frame_data};

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || !receiver_enable_bit)
    begin
      cnt_reg  <= '0;
      rp_reg   <= 1'b0;
      wp_reg   <= 1'b0;
      hold_reg <= 1'b0;
      hold_data_reg <= '0;
      dor_pend_reg  <= 1'b0;
      for (int i = 0; i < `URB_BUF_DEPTH; i++)
        buf_reg[i] <= '0;
    end
    else
    begin
      if (push)
      begin
        buf_reg[wp_reg] <= push_word;
        wp_reg <= ~wp_reg;
      end
      if (pop)
        rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      if (hold_reg && pop)
        hold_reg <= 1'b0;
      // A frame finishing while one is parked is the lost one; the parked one is kept
      else if (frame_done && !push && !hold_reg)
      begin
        hold_reg      <= 1'b1;
        hold_data_reg <= {frame_pe, dor_pend_reg, !stop_bit, frame_data};
      end
      // Full buffer, parked character, new start: frames get lost
      if (hold_reg && tick && state_reg == URB_IDLE && rxd_d_reg && !rxd_s)
        dor_pend_reg <= 1'b1;
      else if (push)
        dor_pend_reg <= 1'b0;
      if (hold_reg && tick && state_reg == URB_IDLE && rxd_d_reg && !rxd_s)
        hold_data_reg[10] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux, ack and outputs
  logic [11:0] head;
  logic        rx_complete_flag;
  assign head = buf_reg[rp_reg];
  assign rx_complete_flag  = (cnt_reg != 2'h0);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end
    else
    begin
      o_wb_ack <= wb_req;
      o_wb_dat <= '0;
      if (wb_req && !i_wb_we)
      begin
        unique case (i_wb_adr)
          `URB_OFF_STATUS_A:
          begin
            o_wb_dat[`URB_A_RXC] <= rx_complete_flag;
            o_wb_dat[`URB_A_FE]  <= rx_complete_flag & head[9];
            o_wb_dat[`URB_A_DOR] <= rx_complete_flag & head[10];
            o_wb_dat[`URB_A_UPE] <= rx_complete_flag & head[11];
            o_wb_dat[`URB_A_U2X] <= u2x_reg;
          end
          `URB_OFF_CONTROL_B:
          begin
            o_wb_dat[7:0] <= ctrl_b_reg;
            o_wb_dat[`URB_B_NINTH_RX_BIT] <= rx_complete_flag & head[8];
          end
          `URB_OFF_CONTROL_C:
          begin
            o_wb_dat[7:0] <= ctrl_c_reg;
            o_wb_dat[16 +: BAUD_W] <= baud_reg;
          end
          `URB_OFF_DATA: o_wb_dat[7:0] <= rx_complete_flag ? head[7:0] : 8'h00;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_rx_irq        <= 1'b0;
      o_rx_pin_owned  <= 1'b0;
      o_overrun_event <= 1'b0;
    end
    else
    begin
      // Only the complete flag requests service
      o_rx_irq <= rx_complete_flag && ctrl_b_reg[`URB_B_RX_COMPLETE_INT_ENABLE] && ctrl_b_reg[`URB_B_GIE];
      o_rx_pin_owned  <= receiver_enable_bit;
      o_overrun_event <= hold_reg && tick && state_reg == URB_IDLE && rxd_d_reg && !rxd_s;
    end
  end
endmodule : urb_receiver

// ===== verilog/urb_consts.svh
// Register offsets, field positions, reset values and sampling constants of the receiver
`ifndef URB_CONSTS_SVH
`define URB_CONSTS_SVH

// Register byte offsets (word aligned)
`define URB_OFF_STATUS_A   4'h0
`define URB_OFF_CONTROL_B  4'h4
`define URB_OFF_CONTROL_C  4'h8
`define URB_OFF_DATA       4'hc
`define URB_OFF_BAUD       4'h0

// control_status_a bits
`define URB_A_RXC          7
`define URB_A_FE           4
`define URB_A_DOR          3
`define URB_A_UPE          2
`define URB_A_U2X          1
// control_status_b bits
`define URB_B_RX_COMPLETE_INT_ENABLE        7
`define URB_B_RECEIVER_ENABLE_BIT         4
`define URB_B_NINTH_RX_BIT         1
`define URB_B_UCSZ2        2
`define URB_B_GIE          0
// control_status_c bits
`define URB_C_PEN          5
`define URB_C_PODD         4
`define URB_C_STOP_BITS_SELECT         3
`define URB_C_CSZ_HI       2
`define URB_C_CSZ_LO       1

// Reset values
`define URB_RST_B          8'h00
`define URB_RST_C          8'h06
`define URB_RST_BAUD       12'h000

// Sampling constants
`define URB_OVS_NORMAL     5'h10
`define URB_OVS_DOUBLE     5'h08
`define URB_VOTE_NORMAL    5'h08
`define URB_VOTE_DOUBLE    5'h04
`define URB_CSZ_NINE       3'h7
`define URB_BUF_DEPTH      2

`endif

// ===== verilog/urb_pkg.sv
// Types shared by the receiver design
package urb_pkg;
  typedef enum logic [4:0] {
    URB_IDLE  = 5'b00001,
    URB_START = 5'b00010,
    URB_DATA  = 5'b00100,
    URB_PAR   = 5'b01000,
    URB_STOP  = 5'b10000
  } urb_state_t;
endpackage : urb_pkg

// ===== verilog/urb_sync.sv
// Two-flop synchroniser for the receive pin
module urb_sync
(
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  // Asynchronous level in, synchronised level out
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_reg;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      meta_reg <= 1'b1;
      o_sync   <= 1'b1;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule : urb_sync

// ===== sim/urb_receiver_sva.sv
// Port checker for the serial receiver, bound to its top module
module urb_receiver_sva
(
  // Clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  // Wishbone slave
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [3:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  // Line, pin handover, events
  input wire logic        i_rxd,
  input wire logic        o_rx_pin_owned,
  input wire logic        o_rx_irq,
  input wire logic        o_overrun_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_ctl_wr;
    s_take ##0 (i_wb_we && i_wb_adr == 4'h4 && i_wb_sel[0]);
  endsequence
  property p_ack_once;
    s_take |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  property p_dat_idle;
    !o_wb_ack |-> o_wb_dat == 32'h0;
  endproperty
  property p_owned_on;
    s_ctl_wr ##0 i_wb_dat[4] |-> ##[1:2] o_rx_pin_owned;
  endproperty
  // Flush must drop the request together with the pin
  property p_release;
    s_ctl_wr ##0 !i_wb_dat[4] |-> ##[1:3] (!o_rx_pin_owned && !o_rx_irq);
  endproperty
  property p_irq_cause;
    $rose(o_rx_irq) |-> o_rx_pin_owned;
  endproperty
  property p_ovr_pulse;
    o_overrun_event |=> !o_overrun_event;
  endproperty
  property p_ovr_owned;
    o_overrun_event |-> o_rx_pin_owned;
  endproperty
  property p_quiet_reset;
    disable iff (1'b0) i_rst |=> !o_wb_ack && !o_rx_irq && !o_rx_pin_owned && !o_overrun_event;
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_once: assert property (p_ack_once)
    else $error("ack not a single cycle after request");
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data not zero outside ack");
  a_owned_on: assert property (p_owned_on)
    else $error("pin not taken after enable");
  a_release: assert property (p_release)
    else $error("pin or request kept after disable");
  a_irq_cause: assert property (p_irq_cause)
    else $error("request raised while receiver off");
  a_ovr_pulse: assert property (p_ovr_pulse)
    else $error("overrun event longer than one cycle");
  a_ovr_owned: assert property (p_ovr_owned)
    else $error("overrun event while receiver off");
  a_quiet_reset: assert property (p_quiet_reset)
    else $error("outputs active after reset edge");
endmodule : urb_receiver_sva

bind urb_receiver urb_receiver_sva urb_receiver_sva_inst (.i_sys_clk, .i_rst, .i_wb_cyc,
  .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_rxd,
  .o_rx_pin_owned, .o_rx_irq, .o_overrun_event);

// ===== sim/urb_line_model.sv
// Remote asynchronous transmitter driving the receive line
module urb_line_model
(
  // Clock
  input  wire logic i_sys_clk,
  // Serial line, idle high
  output logic      o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_clks = 16;
  initial o_line = 1'b1;
  // Called just after a rising edge; returns on the edge that ends the bit
  task automatic hold_bit(input logic b, input int n);
    o_line <= b;
    repeat (n) @(posedge i_sys_clk);
  endtask : hold_bit
  // Start, data LSB first, optional parity, first stop bit
  task automatic send(input logic [8:0] d, input int nb, input logic pen,
                      input logic podd, input logic bad_par, input logic stop);
    logic p;
    p = podd ^ bad_par;
    hold_bit(1'b0, bit_clks);
    for (int i = 0; i < nb; i++)
    begin
      p = p ^ d[i];
      hold_bit(d[i], bit_clks);
    end
    if (pen)
      hold_bit(p, bit_clks);
    hold_bit(stop, bit_clks);
    hold_bit(1'b1, bit_clks);
  endtask : send
  // Low spike shorter than the start validation point
  task automatic glitch();
    hold_bit(1'b0, 3);
    hold_bit(1'b1, 4 * bit_clks);
  endtask : glitch
endmodule : urb_line_model

// ===== sim/uart_receiver_buffer_status_tb.sv
// Self-checking bench for the serial receiver
module uart_receiver_buffer_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, rxd, ack, own, irq;
  logic        ovr, ovr_seen = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  int          error_cnt = 0;
  int          checked = 0;
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (ovr) ovr_seen <= 1'b1;
  urb_receiver urb_receiver_inst (.i_sys_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_rxd(rxd), .o_rx_pin_owned(own), .o_rx_irq(irq),
    .o_overrun_event(ovr));
  urb_line_model urb_line_model_inst (.i_sys_clk(clk), .o_line(rxd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Classic cycle: held until ack is sampled, then released for a cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, 4'hf, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
    if (n == 50)
    begin
      error_cnt++;
      end_of_test();
    end
  endtask : wb
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, exp, q);
  endtask : rd
  task automatic wait_rxc();
    logic [31:0] q;
    for (int n = 0; n < 100; n++)
    begin
      wb(1'b0, 4'h0, 32'h0, q);
      if (q[7] === 1'b1)
        return;
    end
    error_cnt++;
    end_of_test();
  endtask : wait_rxc
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 32'h0, "status after reset");
    chk("pin owned", 32'h0, {31'h0, own});
    wr(4'h8, 32'h6);
    wr(4'h4, 32'h91);
    @(posedge clk);
    chk("pin owned", 32'h1, {31'h0, own});
    urb_line_model_inst.glitch();
    rd(4'h0, 32'h0, "status after spike");
    urb_line_model_inst.send(9'h0a5, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    wait_rxc();
    chk("irq", 32'h1, {31'h0, irq});
    wr(4'h0, 32'h1c);
    rd(4'h0, 32'h80, "status flags");
    rd(4'hc, 32'ha5, "data");
    rd(4'h0, 32'h0, "status empty");
    chk("irq", 32'h0, {31'h0, irq});
    urb_line_model_inst.send(9'h03c, 8, 1'b0, 1'b0, 1'b0, 1'b0);
    wait_rxc();
    rd(4'h0, 32'h90, "frame error");
    rd(4'hc, 32'h3c, "data");
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    for (int k = 0; k < 2; k++)
    begin
      wr(4'h8, 32'h26 | (k << 4));
      urb_line_model_inst.send(9'h05a + k, 8, 1'b1, k[0], 1'b1, 1'b1);
      urb_line_model_inst.send(9'h0c3, 8, 1'b1, k[0], 1'b0, 1'b1);
      wait_rxc();
      rd(4'h0, 32'h84, "parity error");
      rd(4'hc, 32'h5a + k, "data");
      rd(4'h0, 32'h80, "parity ok");
      rd(4'hc, 32'hc3, "data");
    end
    wr(4'h8, 32'h0);
    wr(4'h0, 32'h2);
    urb_line_model_inst.bit_clks = 8;
    urb_line_model_inst.send(9'h1ff, 5, 1'b0, 1'b0, 1'b0, 1'b1);
    wait_rxc();
    rd(4'hc, 32'h1f, "short char");
    urb_line_model_inst.bit_clks = 16;
    wr(4'h0, 32'h0);
    wr(4'h8, 32'h6);
    for (int k = 1; k < 5; k++)
      urb_line_model_inst.send(9'h011 * k, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    chk("overrun event", 32'h1, {31'h0, ovr_seen});
    rd(4'hc, 32'h11, "data");
    rd(4'hc, 32'h22, "data");
    rd(4'h0, 32'h88, "overrun flag");
    rd(4'hc, 32'h33, "data");
    urb_line_model_inst.send(9'h055, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    wait_rxc();
    rd(4'h0, 32'h80, "overrun cleared");
    rd(4'hc, 32'h55, "data");
    wr(4'h4, 32'h95);
    urb_line_model_inst.send(9'h1a5, 9, 1'b0, 1'b0, 1'b0, 1'b1);
    wait_rxc();
    rd(4'h4, 32'h97, "ninth bit");
    rd(4'hc, 32'ha5, "nine bit data");
    wr(4'h4, 32'h91);
    urb_line_model_inst.send(9'h077, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    fork
      urb_line_model_inst.send(9'h066, 8, 1'b0, 1'b0, 1'b0, 1'b1);
      begin
        repeat (60) @(posedge clk);
        wr(4'h4, 32'h81);
      end
    join
    chk("pin owned", 32'h0, {31'h0, own});
    chk("irq", 32'h0, {31'h0, irq});
    wr(4'h4, 32'h91);
    rd(4'h0, 32'h0, "flushed");
    rd(4'h2, 32'h0, "unmapped");
    end_of_test();
  end
endmodule : uart_receiver_buffer_status_tb
